// ### rtl/pte_defs.vh
`ifndef PTE_DEFS_VH
`define PTE_DEFS_VH

// ********************************************
// Clock and timing
// ********************************************
`define PTE_CLK_HZ       32'h05f5e100
`define PTE_CLK_MHZ      100
`define PTE_GAP_NS       3000
`define PTE_GAP_CYC      ((`PTE_GAP_NS * `PTE_CLK_MHZ) / 1000)
`define PTE_RATE_RST     32'h000003e8
`define PTE_PERIOD_RST   (`PTE_CLK_HZ / `PTE_RATE_RST)

// ********************************************
// Register word indices
// ********************************************
`define PTE_OFS_CTRL     6'h00
`define PTE_OFS_RATE     6'h01
`define PTE_OFS_PULSES   6'h02
`define PTE_OFS_STEP     6'h03
`define PTE_OFS_POS      6'h04
`define PTE_OFS_EXPO     6'h05
`define PTE_OFS_STAT     6'h06
`define PTE_OFS_LPOS     6'h07
`define PTE_OFS_LTS      6'h08
`define PTE_OFS_PERIOD   6'h09

// ********************************************
// Control fields
// ********************************************
`define PTE_SRC_LO       0
`define PTE_SRC_HI       1
`define PTE_HIRES_BIT    2
`define PTE_SINGLE_BIT   3
`define PTE_MODE_LO      4
`define PTE_MODE_HI      6
`define PTE_IMG2D_BIT    7
`define PTE_EN_BIT       8

`define PTE_SRC_FREE     2'h0
`define PTE_SRC_ENC      2'h1
`define PTE_SRC_LINE     2'h2

`define PTE_CTRL_RST     9'h000
`define PTE_PULSES_RST   16'h0001
`define PTE_STEP_MAX     14'h2710
`define PTE_EXPO_RST     32'h00000064

`endif

// ### rtl/pte_enc_decode.v
`timescale 1ns/10ps
module pte_enc_decode
(
  input  wire clk,
  input  wire rst_n,
  input  wire enc_a,
  input  wire enc_b,
  input  wire line_in,
  input  wire hires,
  input  wire single,
  output reg  step_up,
  output reg  step_down,
  output reg  line_rise
);

  // ********************************************
  // Synchronisers
  // ********************************************
  reg [2:0] sync1;
  reg [2:0] sync2;
  reg [2:0] prev;
  reg       armed;

  // Quadrature phase index 00,01,11,10 -> 0..3
  function [1:0] phase_idx;
    input a;
    input b;
    phase_idx = {a, a ^ b};
  endfunction

  wire [1:0] cur      = phase_idx(sync2[2], sync2[1]);
  wire [1:0] old      = phase_idx(prev[2], prev[1]);
  wire       fwd_edge = (cur == old + 2'h1);
  wire       bwd_edge = (cur == old - 2'h1);
  wire       a_rise   = sync2[2] & ~prev[2];

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync1     <= 3'h0;
      sync2     <= 3'h0;
      prev      <= 3'h0;
      armed     <= 1'b0;
      step_up   <= 1'b0;
      step_down <= 1'b0;
      line_rise <= 1'b0;
    end
    else
    begin
      sync1     <= {enc_a, enc_b, line_in};
      sync2     <= sync1;
      prev      <= sync2;
      line_rise <= sync2[0] & ~prev[0];
      step_up   <= 1'b0;
      step_down <= 1'b0;
      if (single)
        step_up <= a_rise;
      else if (hires)
      begin
        step_up   <= fwd_edge;
        step_down <= bwd_edge;
      end
      else
      begin
        // Full cycle needed: rearm only at phase 0
        if (cur == 2'h0)
          armed <= 1'b1;
        if (fwd_edge && cur == 2'h3 && armed)
        begin
          step_up <= 1'b1;
          armed   <= 1'b0;
        end
        if (bwd_edge && cur == 2'h1 && armed)
        begin
          step_down <= 1'b1;
          armed     <= 1'b0;
        end
      end
    end
  end

endmodule // pte_enc_decode

// ### rtl/pte_trigger.v
// Added by the designer: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
`include "pte_defs.vh"
module pte_trigger
#(
  parameter RST_PERIOD = `PTE_PERIOD_RST
)
(
  input  wire        clk,
  input  wire        rst_n,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        enc_a,
  input  wire        enc_b,
  input  wire        line_trig,
  output reg         profile_trig,
  output reg         expose
);

  localparam [2:0] pos_track_positive = 3'h0;
  localparam [2:0] pos_track_negative = 3'h1;
  localparam [2:0] dir_track_positive = 3'h2;
  localparam [2:0] dir_track_negative = 3'h3;
  localparam [2:0] motion_track       = 3'h4;
  localparam [1:0] div_idle = 2'h0;
  localparam [1:0] div_run  = 2'h1;

  // ********************************************
  // Registers
  // ********************************************
  reg [8:0]  ctrl;
  reg [31:0] rate;
  reg [15:0] pulses;
  reg [13:0] step_size;
  reg [31:0] pos;
  reg [31:0] expo;
  reg [31:0] period;
  reg [31:0] line_pos;
  reg [31:0] line_ts;
  reg [15:0] trig_cnt;
  reg        last_fwd;
  reg        wr_pend;
  reg [5:0]  wr_idx;
  reg [1:0]  div_state;
  reg [5:0]  div_bit;
  reg [31:0] div_rem;
  reg [31:0] div_quo;
  reg [15:0] acc;
  reg [31:0] debt;
  reg        pending;
  reg [31:0] since;
  reg [31:0] tstamp;
  reg [31:0] exp_left;
  wire step_up;
  wire step_down;
  wire line_rise;
  wire [1:0] src       = ctrl[`PTE_SRC_HI:`PTE_SRC_LO];
  wire [2:0] mode      = ctrl[`PTE_MODE_HI:`PTE_MODE_LO];
  wire       mode_ok   = (mode == motion_track);
  wire       single_on = ctrl[`PTE_SINGLE_BIT] & mode_ok;
  wire       enabled   = ctrl[`PTE_EN_BIT];
  // 2D image triggering overrides the source choice
  wire [1:0] eff_src = ctrl[`PTE_IMG2D_BIT] ? `PTE_SRC_ENC : src;

  // ********************************************
  // Encoder front end
  // ********************************************
  pte_enc_decode u_dec
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .enc_a     (enc_a),
    .enc_b     (enc_b),
    .line_in   (line_trig),
    .hires     (ctrl[`PTE_HIRES_BIT]),
    .single    (single_on),
    .step_up   (step_up),
    .step_down (step_down),
    .line_rise (line_rise)
  );

  // Forward/backward per selected polarity
  wire neg_mode = (mode == pos_track_negative) ||
                  (mode == dir_track_negative);
  wire fwd      = neg_mode ? step_down : step_up;
  wire bwd      = neg_mode ? step_up   : step_down;

  // ********************************************
  // Pulse qualification
  // ********************************************
  reg qualify;
  reg [31:0] next_debt;
  always @*
  begin
    qualify   = 1'b0;
    next_debt = debt;
    case (mode)
      pos_track_positive, pos_track_negative:
      begin
        if (bwd)
          next_debt = debt + 32'h1;
        else if (fwd && debt != 32'h0)
          next_debt = debt - 32'h1;
        else
          qualify = fwd;
      end
      dir_track_positive, dir_track_negative: qualify = fwd;
      motion_track: qualify = step_up | step_down;
      default:      qualify = 1'b0;
    endcase
  end

  // ********************************************
  // Register read decode
  // ********************************************
  function [31:0] rd_mux;
    input [5:0] idx;
    begin
      case (idx)
        `PTE_OFS_CTRL:   rd_mux = {23'h0, ctrl};
        `PTE_OFS_RATE:   rd_mux = rate;
        `PTE_OFS_PULSES: rd_mux = {16'h0, pulses};
        `PTE_OFS_STEP:   rd_mux = {18'h0, step_size};
        `PTE_OFS_POS:    rd_mux = pos;
        `PTE_OFS_EXPO:   rd_mux = expo;
        `PTE_OFS_STAT:   rd_mux = {trig_cnt, 13'h0,
                                   div_state == div_run, last_fwd, pending};
        `PTE_OFS_LPOS:   rd_mux = line_pos;
        `PTE_OFS_LTS:    rd_mux = line_ts;
        `PTE_OFS_PERIOD: rd_mux = period;
        default:         rd_mux = 32'h0;
      endcase
    end
  endfunction

  wire addr_ok  = hsel && hready && htrans[1];
  wire do_write = wr_pend;
  wire pos_clr  = do_write && wr_idx == `PTE_OFS_POS;
  wire rate_wr  = do_write && wr_idx == `PTE_OFS_RATE;

  // ********************************************
  // AHB-Lite slave, zero wait states
  // ********************************************
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= 1'b0;
      wr_idx    <= 6'h0;
      ctrl      <= `PTE_CTRL_RST;
      rate      <= `PTE_RATE_RST;
      pulses    <= `PTE_PULSES_RST;
      step_size <= 14'h0;
      expo      <= `PTE_EXPO_RST;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= addr_ok && hwrite;
      if (addr_ok)
        wr_idx <= haddr[7:2];
      if (addr_ok && !hwrite)
        hrdata <= rd_mux(haddr[7:2]);
      if (do_write)
      begin
        case (wr_idx)
          `PTE_OFS_CTRL:   ctrl <= hwdata[8:0];
          `PTE_OFS_RATE:   rate <= hwdata;
          `PTE_OFS_PULSES: pulses <= hwdata[15:0];
          `PTE_OFS_STEP:
            step_size <= (hwdata > {18'h0, `PTE_STEP_MAX}) ?
                         `PTE_STEP_MAX : hwdata[13:0];
          `PTE_OFS_EXPO:   expo <= hwdata;
          default:         ctrl <= ctrl;
        endcase
      end
    end
  end

  // ********************************************
  // Rate to period divider
  // ********************************************
  wire [32:0] trial = {div_rem[31:0], div_quo[31]} - {1'b0, rate};

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      div_state <= div_idle;
      div_bit   <= 6'h0;
      div_rem   <= 32'h0;
      div_quo   <= 32'h0;
      period    <= RST_PERIOD;
    end
    else
    begin
      case (div_state)
        div_idle:
          if (rate_wr)
          begin
            div_state <= div_run;
            div_bit   <= 6'h20;
            div_rem   <= 32'h0;
            div_quo   <= `PTE_CLK_HZ;
          end
        div_run:
        begin
          if (trial[32])
          begin
            div_rem <= {div_rem[30:0], div_quo[31]};
            div_quo <= {div_quo[30:0], 1'b0};
          end
          else
          begin
            div_rem <= trial[31:0];
            div_quo <= {div_quo[30:0], 1'b1};
          end
          div_bit <= div_bit - 6'h1;
          if (div_bit == 6'h1)
          begin
            div_state <= div_idle;
            // Rate zero or above clock: fall back to one cycle
            period    <= (rate == 32'h0 || div_quo[30:0] == 31'h0 &&
                          trial[32]) ? 32'h1 :
                         {div_quo[30:0], ~trial[32]};
          end
        end
        default: div_state <= div_idle;
      endcase
    end
  end

  // ********************************************
  // Position and counting
  // ********************************************
  wire period_done = (since >= period);
  wire enc_hit     = qualify && (acc + 16'h1 >= pulses);
  wire want_trig   = (eff_src == `PTE_SRC_FREE) ? period_done :
                     pending && period_done;
  wire fire        = enabled && want_trig;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      pos      <= 32'h0;
      debt     <= 32'h0;
      acc      <= 16'h0;
      pending  <= 1'b0;
      last_fwd <= 1'b1;
    end
    else
    begin
      // Position tracks in every source
      if (pos_clr)
        pos <= 32'h0;
      else if (step_up)
        pos <= pos + 32'h1;
      else if (step_down)
        pos <= pos - 32'h1;
      if (fwd)
        last_fwd <= 1'b1;
      else if (bwd)
        last_fwd <= 1'b0;
      if (eff_src == `PTE_SRC_ENC && enabled)
      begin
        debt <= next_debt;
        if (enc_hit)
          acc <= 16'h0;
        else if (qualify)
          acc <= acc + 16'h1;
      end
      else
      begin
        debt <= 32'h0;
        acc  <= 16'h0;
      end
      // New request wins over the clear of an old one
      if ((eff_src == `PTE_SRC_ENC && enabled && enc_hit) ||
          (eff_src == `PTE_SRC_LINE && enabled && line_rise))
        pending <= 1'b1;
      else if (fire || !enabled || eff_src == `PTE_SRC_FREE)
        pending <= 1'b0;
    end
  end

  // ********************************************
  // Trigger, meta data and exposure
  // ********************************************
  wire [31:0] exp_cap = (period > `PTE_GAP_CYC) ?
                        period - `PTE_GAP_CYC : 32'h0;
  wire [31:0] exp_len = (expo < exp_cap) ? expo : exp_cap;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      since        <= 32'h0;
      tstamp       <= 32'h0;
      profile_trig <= 1'b0;
      expose       <= 1'b0;
      exp_left     <= 32'h0;
      line_pos     <= 32'h0;
      line_ts      <= 32'h0;
      trig_cnt     <= 16'h0;
    end
    else
    begin
      tstamp       <= tstamp + 32'h1;
      profile_trig <= fire;
      if (fire)
      begin
        since    <= 32'h1;
        line_pos <= pos;
        line_ts  <= tstamp;
        trig_cnt <= trig_cnt + 16'h1;
        exp_left <= exp_len;
        expose   <= (exp_len != 32'h0);
      end
      else
      begin
        if (!period_done)
          since <= since + 32'h1;
        if (exp_left != 32'h0)
          exp_left <= exp_left - 32'h1;
        expose <= (exp_left > 32'h1);
      end
    end
  end

endmodule // pte_trigger

// ### verif/pte_trigger_assertions.sv
`timescale 1ns/10ps
module pte_trig_chk
#(
  parameter RST_PERIOD = 50
)
(
  input wire        clk,
  input wire        rst_n,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [2:0]  hsize,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        enc_a,
  input wire        enc_b,
  input wire        line_trig,
  input wire        profile_trig,
  input wire        expose
);
  reg [31:0] since_trig;

  // Cycles since the last trigger, saturating
  always @(posedge clk)
  begin
    if (!rst_n)
      since_trig <= RST_PERIOD;
    else if (profile_trig)
      since_trig <= 32'h1;
    else if (since_trig < RST_PERIOD)
      since_trig <= since_trig + 32'h1;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_rd;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence s_rd_unmapped;
    s_rd ##0 (haddr[7:2] > 6'h09);
  endsequence

  property p_okay;
    hresp == 1'b0;
  endproperty
  property p_ready;
    hreadyout == 1'b1;
  endproperty
  property p_one_cycle;
    profile_trig |=> !profile_trig;
  endproperty
  property p_min_gap;
    profile_trig |-> since_trig >= RST_PERIOD;
  endproperty
  property p_expo_gap;
    profile_trig |-> !$past(expose);
  endproperty
  property p_reset;
    disable iff (1'b0)
    !rst_n |=> (hrdata == 32'h0 && !profile_trig && !expose);
  endproperty
  property p_hold;
    !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata);
  endproperty
  property p_unmapped;
    s_rd_unmapped |=> hrdata == 32'h0;
  endproperty

  a_okay: assert property (p_okay)
    else $error("bus response not okay");
  a_ready: assert property (p_ready)
    else $error("bus wait state seen");
  a_one_cycle: assert property (p_one_cycle)
    else $error("trigger longer than one cycle");
  a_min_gap: assert property (p_min_gap)
    else $error("triggers closer than period");
  a_expo_gap: assert property (p_expo_gap)
    else $error("exposure still on at trigger");
  a_reset: assert property (p_reset)
    else $error("outputs not cleared in reset");
  a_hold: assert property (p_hold)
    else $error("read data moved without read");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped word not zero");
endmodule // pte_trig_chk

bind pte_trigger pte_trig_chk #(.RST_PERIOD(RST_PERIOD)) u_chk
(
  .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .enc_a(enc_a), .enc_b(enc_b), .line_trig(line_trig),
  .profile_trig(profile_trig), .expose(expose)
);

// ### verif/pte_enc_model.sv
`timescale 1ns/10ps
module pte_enc_model
#(
  parameter HOLD = 20
)
(
  input  wire clk,
  output reg  enc_a,
  output reg  enc_b,
  output reg  line_trig
);
  reg [1:0] ph;

  initial
  begin
    ph = 2'h0;
    enc_a = 1'b0;
    enc_b = 1'b0;
    line_trig = 1'b0;
  end

  // Quadrature cycles, forward order AB 00 01 11 10
  task move(input integer n, input bit fw);
    repeat (4 * n)
    begin
      ph = fw ? ph + 2'h1 : ph - 2'h1;
      enc_a <= ph[1];
      enc_b <= ph[1] ^ ph[0];
      repeat (HOLD) @(posedge clk);
    end
  endtask

  task pulse_a(input integer n);
    repeat (n)
    begin
      enc_a <= 1'b1;
      repeat (HOLD) @(posedge clk);
      enc_a <= 1'b0;
      repeat (HOLD) @(posedge clk);
    end
  endtask

  // One pulse per wanted profile
  task line(input integer n);
    repeat (n)
    begin
      line_trig <= 1'b1;
      repeat (HOLD) @(posedge clk);
      line_trig <= 1'b0;
      repeat (4 * HOLD) @(posedge clk);
    end
  endtask
endmodule // pte_enc_model

// ### verif/profile_trigger_encoder_logic_tb.sv
`timescale 1ns/10ps
`include "pte_defs.vh"
module profile_trigger_encoder_logic_tb;
  reg         clk;
  reg         rst_n;
  reg         hsel;
  reg  [31:0] haddr;
  reg  [1:0]  htrans;
  reg         hwrite;
  reg  [2:0]  hsize;
  reg  [31:0] hwdata;
  wire [31:0] hrdata;
  wire        hreadyout;
  wire        hresp;
  wire        enc_a;
  wire        enc_b;
  wire        line_trig;
  wire        profile_trig;
  wire        expose;
  integer     errors;
  integer     cmp_count;
  reg  [31:0] cyc;
  reg  [31:0] trig_cnt;
  reg  [31:0] d;
  reg  [31:0] p;
  reg  [31:0] t0;
  integer     n;

  pte_trigger #(.RST_PERIOD(50)) uut
  (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .enc_a(enc_a), .enc_b(enc_b), .line_trig(line_trig),
    .profile_trig(profile_trig), .expose(expose)
  );

  pte_enc_model em
  (
    .clk(clk), .enc_a(enc_a), .enc_b(enc_b), .line_trig(line_trig)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 32'h1;
    if (profile_trig === 1'b1)
      trig_cnt <= trig_cnt + 32'h1;
  end

  // ****************************************
  // Bus access and checks
  // ****************************************
  function [31:0] adr(input [5:0] i);
    adr = {24'h0, i, 2'b00};
  endfunction

  task ahb(input w, input [31:0] a, input [31:0] wd, output [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task chk(input [31:0] got, input [31:0] ex);
    cmp_count = cmp_count + 1;
    if (got !== ex)
    begin
      errors = errors + 1;
      $display("BAD %0t got %h expected %h", $time, got, ex);
    end
  endtask

  task rdc(input [5:0] i, input [31:0] ex);
    ahb(1'b0, adr(i), 32'h0, d);
    chk(d, ex);
  endtask

  task wtrig;
    integer k;
    k = 0;
    while (profile_trig !== 1'b1 && k < 3000)
    begin
      @(posedge clk);
      k = k + 1;
    end
    if (k == 3000)
      chk(32'h0, 32'h1);
  endtask

  task run(input [31:0] c, input [31:0] pl, input integer kind,
           input integer n1, input integer n2, input [31:0] ex);
    reg [31:0] base;
    ahb(1'b1, adr(`PTE_OFS_PULSES), pl, d);
    ahb(1'b1, adr(`PTE_OFS_CTRL), c, d);
    repeat (100) @(posedge clk);
    base = trig_cnt;
    if (kind < 2)
      em.move(n1, kind == 0);
    if (kind < 2)
      em.move(n2, kind != 0);
    if (kind == 2)
      em.pulse_a(n1);
    if (kind == 3)
      em.line(n1);
    repeat (150) @(posedge clk);
    chk(trig_cnt - base, ex);
  endtask

  task print_verdict;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    errors = errors + 1;
    print_verdict;
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    errors = 0;
    cmp_count = 0;
    cyc = 32'h0;
    trig_cnt = 32'h0;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(`PTE_OFS_CTRL, `PTE_CTRL_RST);
    rdc(`PTE_OFS_RATE, `PTE_RATE_RST);
    rdc(`PTE_OFS_PULSES, `PTE_PULSES_RST);
    rdc(`PTE_OFS_EXPO, `PTE_EXPO_RST);
    rdc(`PTE_OFS_PERIOD, 32'h32);
    rdc(6'h0f, 32'h0);
    run(32'h141, 2, 0, 2, 2, 2);
    run(32'h109, 1, 0, 1, 0, 1);
    run(32'h101, 1, 1, 2, 3, 1);
    run(32'h111, 1, 0, 2, 3, 1);
    run(32'h121, 1, 1, 2, 1, 1);
    run(32'h131, 1, 0, 2, 1, 1);
    run(32'h145, 4, 0, 1, 0, 1);
    run(32'h149, 2, 2, 2, 0, 1);
    run(32'h1c0, 1, 0, 1, 0, 1);
    run(32'h102, 1, 3, 2, 0, 2);
    ahb(1'b1, adr(`PTE_OFS_POS), 32'h1234, d);
    rdc(`PTE_OFS_POS, 32'h0);
    ahb(1'b1, adr(`PTE_OFS_STEP), 32'h4e20, d);
    rdc(`PTE_OFS_STEP, `PTE_STEP_MAX);
    ahb(1'b1, adr(`PTE_OFS_RATE), 32'h186a0, d);
    repeat (40) @(posedge clk);
    rdc(`PTE_OFS_PERIOD, `PTE_CLK_HZ / 32'h186a0);
    ahb(1'b1, adr(`PTE_OFS_EXPO), 32'h320, d);
    ahb(1'b1, adr(`PTE_OFS_CTRL), 32'h110, d);
    ahb(1'b0, adr(`PTE_OFS_POS), 32'h0, p);
    em.move(1, 1'b1);
    rdc(`PTE_OFS_POS, p + 32'h1);
    wtrig;
    t0 = cyc;
    @(posedge clk);
    wtrig;
    chk(cyc - t0, 32'h3e8);
    n = 0;
    while (expose !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n = n + 1;
    end
    n = 0;
    while (expose === 1'b1 && n < 2000)
    begin
      n = n + 1;
      @(posedge clk);
    end
    chk(n, 1000 - `PTE_GAP_CYC);
    rdc(`PTE_OFS_LPOS, p + 32'h1);
    ahb(1'b1, adr(`PTE_OFS_CTRL), 32'h145, d);
    repeat (1100) @(posedge clk);
    t0 = trig_cnt;
    em.move(4, 1'b1);
    repeat (1500) @(posedge clk);
    chk(trig_cnt - t0, 32'h2);
    rdc(`PTE_OFS_STAT, {trig_cnt[15:0], 16'h0002});
    print_verdict;
  end
endmodule // profile_trigger_encoder_logic_tb
